// ==== hdl/seq_boot_pkg.sv ====
// Shared constants and timing helpers for the post-reset self-test and boot load sequencer
package seq_boot_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 24;
  localparam int HALF_W = 8;

  // ----------------------------------------------------------------
  // Clock and serial timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_PERIOD_PS = 5000;
  localparam int unsigned SROM_PERIOD_CPU = 126;
  localparam int unsigned ROM_SETUP_FACTOR = 5;
  localparam int unsigned RATIO_3 = 3;
  localparam int unsigned RATIO_4 = 4;
  localparam int unsigned RATIO_15 = 15;

  // Self-test end, in CPU cycles, per ratio
  localparam int unsigned BIST_END_CPU_R3 = 67935;
  localparam int unsigned BIST_END_CPU_R4 = 78888;
  localparam int unsigned BIST_END_CPU_R15 = 199380;

  // Boot load end, in CPU cycles, per ratio
  localparam int unsigned LOAD_END_CPU_R3 = 13224651;
  localparam int unsigned LOAD_END_CPU_R4 = 13224776;
  localparam int unsigned LOAD_END_CPU_R15 = 13224780;

  // Self-test memory pattern seed
  localparam logic [31:0] BIST_SEED = 32'h5a3c_96e1;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_HOLD = 4'b0001,
    ST_BIST = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_RUN  = 4'b1000
  } seq_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int unsigned ceil_div(input int unsigned num, input int unsigned den);
    return (num + den - 1) / den;
  endfunction : ceil_div

  function automatic int unsigned bist_end_cpu(input int unsigned ratio);
    if (ratio == RATIO_3) return BIST_END_CPU_R3;
    if (ratio == RATIO_4) return BIST_END_CPU_R4;
    return BIST_END_CPU_R15;
  endfunction : bist_end_cpu

  function automatic int unsigned load_end_cpu(input int unsigned ratio);
    if (ratio == RATIO_3) return LOAD_END_CPU_R3;
    if (ratio == RATIO_4) return LOAD_END_CPU_R4;
    return LOAD_END_CPU_R15;
  endfunction : load_end_cpu

  // Half period of the serial clock in system cycles, never below one
  function automatic int unsigned srom_half_sys(input int unsigned ratio);
    int unsigned half;
    half = ceil_div(SROM_PERIOD_CPU, ratio) / 2;
    return (half == 0) ? 1 : half;
  endfunction : srom_half_sys

endpackage : seq_boot_pkg

// ==== hdl/icache_store.sv ====
// Single-port instruction cache array with registered read data
`timescale 1ns/1ps
module icache_store #(
  parameter int WORDS = 64,
  parameter int WIDTH = 32,
  parameter int ADDR_W = 6
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [WORDS];

  // ----------------------------------------------------------------
  // Array access
  // ----------------------------------------------------------------
  // Read data is registered; a write returns the old contents
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end

endmodule : icache_store

// ==== hdl/reset_selftest_srom_load_sequencer.sv ====
// Post-reset sequencer: cache self-test, optional serial ROM load, core reset release
`timescale 1ns/1ps
module reset_selftest_srom_load_sequencer
  import seq_boot_pkg::*;
#(
  parameter int unsigned CLK_RATIO = seq_boot_pkg::RATIO_3,
  parameter int unsigned BIST_END_SYS = seq_boot_pkg::ceil_div(seq_boot_pkg::bist_end_cpu(CLK_RATIO), CLK_RATIO),
  parameter int unsigned LOAD_END_SYS = seq_boot_pkg::ceil_div(seq_boot_pkg::load_end_cpu(CLK_RATIO), CLK_RATIO),
  parameter int unsigned SROM_HALF = seq_boot_pkg::srom_half_sys(CLK_RATIO),
  parameter int ICACHE_WORDS = 64,
  parameter int WORD_W = 32
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ext_reset_n,
  input wire logic rom_present_n,
  input wire logic srom_data,
  output logic srom_clk,
  output logic srom_oe_n,
  output logic core_reset,
  output logic bist_fail,
  output logic bist_busy,
  output logic load_busy
);

  import seq_boot_pkg::*;

  localparam int ADDR_W = $clog2(ICACHE_WORDS);
  localparam int BIT_W = $clog2(WORD_W);
  localparam logic [CNT_W-1:0] BIST_LAST = CNT_W'(BIST_END_SYS - 1);
  localparam logic [CNT_W-1:0] LOAD_LAST = CNT_W'(LOAD_END_SYS - 1);
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(SROM_HALF - 1);
  localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(ICACHE_WORDS - 1);
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(WORD_W - 1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic rel_s1, rel_s2, rom_s1, rom_s2;

  // Both pins are asynchronous; a synchronous release just costs the same two edges
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rel_s1 <= 1'b0;
      rel_s2 <= 1'b0;
      rom_s1 <= 1'b0;
      rom_s2 <= 1'b0;
    end else begin
      rel_s1 <= ext_reset_n;
      rel_s2 <= rel_s1;
      rom_s1 <= ~rom_present_n;
      rom_s2 <= rom_s1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state and interval counter
  // ----------------------------------------------------------------
  seq_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic bist_end, load_end;

  assign bist_end = (state == ST_BIST) && (cnt == BIST_LAST);
  assign load_end = (state == ST_LOAD) && (cnt == LOAD_LAST);

  // Counter restarts at zero on each state entry, so the first self-test
  // cycle is the first edge after the synchronised release
  always_comb begin
    next_state = state;
    next_cnt = cnt + CNT_W'(1);
    unique case (state)
      ST_HOLD: begin
        next_cnt = '0;
        if (rel_s2) begin
          next_state = ST_BIST;
        end
      end
      ST_BIST: begin
        if (bist_end) begin
          next_cnt = '0;
          next_state = rom_s2 ? ST_LOAD : ST_RUN;
        end
      end
      ST_LOAD: begin
        if (load_end) begin
          next_cnt = '0;
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_cnt = '0;
      end
    endcase
    if (!rel_s2) begin
      next_state = ST_HOLD;
      next_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_HOLD;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Cache self-test walk: write every word, then read and compare
  // ----------------------------------------------------------------
  logic bist_rd_phase, next_bist_rd_phase;
  logic bist_walk_done, next_bist_walk_done;
  logic [ADDR_W-1:0] bist_addr, next_bist_addr;
  logic cmp_valid, next_cmp_valid;
  logic [ADDR_W-1:0] cmp_addr, next_cmp_addr;
  logic next_bist_fail;
  logic [WORD_W-1:0] rd_data;

  function automatic logic [WORD_W-1:0] pattern(input logic [ADDR_W-1:0] a);
    return WORD_W'(a) ^ WORD_W'(BIST_SEED);
  endfunction : pattern

  // Walk finishes early; the fixed interval keeps release timing deterministic
  always_comb begin
    next_bist_rd_phase = bist_rd_phase;
    next_bist_walk_done = bist_walk_done;
    next_bist_addr = bist_addr;
    next_cmp_valid = 1'b0;
    next_cmp_addr = bist_addr;
    next_bist_fail = bist_fail;
    if (cmp_valid && (rd_data != pattern(cmp_addr))) begin
      next_bist_fail = 1'b1;
    end
    if (state == ST_BIST && !bist_walk_done) begin
      next_bist_addr = bist_addr + ADDR_W'(1);
      next_cmp_valid = bist_rd_phase;
      if (bist_addr == ADDR_LAST) begin
        next_bist_rd_phase = 1'b1;
        next_bist_walk_done = bist_rd_phase;
      end
    end
    if (state == ST_HOLD) begin
      next_bist_rd_phase = 1'b0;
      next_bist_walk_done = 1'b0;
      next_bist_addr = '0;
      next_bist_fail = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bist_rd_phase <= 1'b0;
      bist_walk_done <= 1'b0;
      bist_addr <= '0;
      cmp_valid <= 1'b0;
      cmp_addr <= '0;
      bist_fail <= 1'b0;
    end else begin
      bist_rd_phase <= next_bist_rd_phase;
      bist_walk_done <= next_bist_walk_done;
      bist_addr <= next_bist_addr;
      cmp_valid <= next_cmp_valid;
      cmp_addr <= next_cmp_addr;
      bist_fail <= next_bist_fail;
    end
  end

  // ----------------------------------------------------------------
  // Serial ROM clocking and bit assembly
  // ----------------------------------------------------------------
  logic [HALF_W-1:0] half_cnt, next_half_cnt;
  logic next_srom_clk, next_srom_oe_n;
  logic [WORD_W-1:0] shift, next_shift;
  logic [BIT_W-1:0] bit_cnt, next_bit_cnt;
  logic [ADDR_W-1:0] load_addr, next_load_addr;
  logic load_full, next_load_full;
  logic load_wr;
  logic rise;

  // Rising edge of the serial clock is where a bit is taken; the ROM must have
  // settled it since the previous rising edge
  assign rise = (state == ST_LOAD) && !load_full && !srom_clk && (half_cnt == HALF_LAST);
  assign load_wr = rise && (bit_cnt == BIT_LAST);

  // Clock stops once the cache is full, but core reset still waits out the interval
  always_comb begin
    next_half_cnt = '0;
    next_srom_clk = 1'b0;
    next_srom_oe_n = 1'b1;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_load_addr = load_addr;
    next_load_full = load_full;
    if (state == ST_LOAD && !load_end) begin
      next_srom_oe_n = 1'b0;
      next_srom_clk = srom_clk;
      if (!load_full || srom_clk) begin // Last high half runs out, so the clock parks low
        next_half_cnt = half_cnt + HALF_W'(1);
        if (half_cnt == HALF_LAST) begin
          next_half_cnt = '0;
          next_srom_clk = ~srom_clk;
        end
      end
      if (rise) begin
        next_shift = {shift[WORD_W-2:0], srom_data};
        next_bit_cnt = bit_cnt + BIT_W'(1);
      end
      if (load_wr) begin
        next_load_addr = load_addr + ADDR_W'(1);
        next_load_full = (load_addr == ADDR_LAST);
      end
    end
    if (state != ST_LOAD) begin
      next_bit_cnt = '0;
      next_load_addr = '0;
      next_load_full = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      half_cnt <= '0;
      srom_clk <= 1'b0;
      srom_oe_n <= 1'b1;
      shift <= '0;
      bit_cnt <= '0;
      load_addr <= '0;
      load_full <= 1'b0;
    end else begin
      half_cnt <= next_half_cnt;
      srom_clk <= next_srom_clk;
      srom_oe_n <= next_srom_oe_n;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      load_addr <= next_load_addr;
      load_full <= next_load_full;
    end
  end

  // ----------------------------------------------------------------
  // Cache array shared by the self-test and the loader
  // ----------------------------------------------------------------
  logic mem_wr;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_wdata;
  logic [WORD_W-1:0] load_word;

  assign load_word = {shift[WORD_W-2:0], srom_data};
  assign mem_wr = (state == ST_BIST && !bist_walk_done && !bist_rd_phase) || load_wr;
  assign mem_addr = (state == ST_LOAD) ? load_addr : bist_addr;
  assign mem_wdata = (state == ST_LOAD) ? load_word : pattern(bist_addr);

  icache_store #(
    .WORDS(ICACHE_WORDS),
    .WIDTH(WORD_W),
    .ADDR_W(ADDR_W)
  ) u_store (
    .clk_sys(clk_sys),
    .wr_en(mem_wr),
    .addr(mem_addr),
    .wr_data(mem_wdata),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic next_core_reset;

  // Core stays in reset in every state but run
  assign next_core_reset = (next_state != ST_RUN);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= next_core_reset;
    end
  end

  assign bist_busy = (state == ST_BIST);
  assign load_busy = (state == ST_LOAD);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_sync_two_stage: assert property (@(posedge clk_sys) disable iff (reset)
    rel_s2 == $past(ext_reset_n, 2) || $past(reset, 2) || $past(reset))
    else $error("Release level not two edges behind the pin");

  a_bist_start: assert property (@(posedge clk_sys) disable iff (reset)
    (state == ST_HOLD && rel_s2) |=> (state == ST_BIST && cnt == '0))
    else $error("Self-test did not start on release");

  a_bist_origin: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(state == ST_BIST) |-> (cnt == '0) ##1 (cnt == CNT_W'(1) || state != ST_BIST))
    else $error("Self-test interval not counted from first edge");

  a_bist_length: assert property (@(posedge clk_sys) disable iff (reset)
    (state == ST_BIST && $past(state) == ST_BIST && !$past(bist_end)) |-> cnt == $past(cnt) + CNT_W'(1))
    else $error("Self-test interval counter skipped");

  a_no_rom_release: assert property (@(posedge clk_sys) disable iff (reset)
    (bist_end && !rom_s2 && rel_s2) |=> (!core_reset && state == ST_RUN))
    else $error("Core reset not released at self-test end");

  a_load_start: assert property (@(posedge clk_sys) disable iff (reset)
    (bist_end && rom_s2 && rel_s2) |=> (state == ST_LOAD && core_reset) ##1 !srom_oe_n)
    else $error("Serial load did not start at self-test end");

  a_load_holds_core: assert property (@(posedge clk_sys) disable iff (reset)
    (state == ST_LOAD) |-> core_reset)
    else $error("Core reset dropped during serial load");

  a_load_length: assert property (@(posedge clk_sys) disable iff (reset)
    (load_end && rel_s2) |=> (state == ST_RUN && !core_reset && srom_oe_n))
    else $error("Load did not end at the load interval");

  a_srom_half: assert property (@(posedge clk_sys) disable iff (reset)
    ($changed(srom_clk) && state == ST_LOAD && $past(state) == ST_LOAD && $past(srom_clk) == 1'b0)
      |-> $past(half_cnt) == HALF_LAST)
    else $error("Serial clock half period wrong");

endmodule : reset_selftest_srom_load_sequencer

// ==== testbench/srom_model.sv ====
// Behavioural serial boot ROM and board presence strap facing the sequencer
`timescale 1ns/1ps
module srom_model (
  input wire logic clk_sys,
  input wire logic fitted,
  input wire logic slow,
  input wire logic srom_clk,
  input wire logic srom_oe_n,
  output logic srom_data,
  output logic rom_present_n
);
  // ----------------------------------------------------------------
  // Contents and state
  // ----------------------------------------------------------------
  logic [11:0] bit_idx;
  logic clk_q;
  logic lag;
  logic idle_bit;

  // Word w holds a pattern built from its own index, sent MSB first
  function automatic logic rom_bit(input logic [11:0] i);
    logic [31:0] word;
    word = {i[11:5] ^ 7'h55, 1'b1, ~i[11:5], 1'b0, i[11:5], 2'h2, ~i[11:5] ^ 7'h2a};
    return word[5'd31 - i[4:0]];
  endfunction : rom_bit

  // Strap follows the bench's choice of a fitted part
  assign rom_present_n = ~fitted;

  initial begin
    bit_idx = 12'h000;
    clk_q = 1'b0;
    lag = 1'b0;
    idle_bit = 1'b0;
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Current bit shows as soon as the part is enabled, so even a short first half finds it settled
  assign srom_data = srom_oe_n ? idle_bit : rom_bit(bit_idx);
  // Index moves one cycle after each clock rise, or two when slow, well inside the setup budget;
  // a released line shows the inverse of its last level so it never looks like valid data
  always @(posedge clk_sys) begin
    clk_q <= srom_clk;
    idle_bit <= ~srom_data;
    if (srom_oe_n) begin
      bit_idx <= 12'h000;
      lag <= 1'b0;
    end else begin
      lag <= srom_clk && !clk_q && slow;
      if ((srom_clk && !clk_q && !slow) || lag) begin
        bit_idx <= bit_idx + 12'h001;
      end
    end
  end
endmodule : srom_model

// ==== testbench/tb_reset_selftest_srom_load_sequencer.sv ====
// Self-checking bench for the post-reset self-test and boot load sequencer
`timescale 1ns/1ps
module tb_reset_selftest_srom_load_sequencer;
  import seq_boot_pkg::*;
  // ----------------------------------------------------------------
  // Shortened counts keep the run short; the ROM still sends 64 words
  // ----------------------------------------------------------------
  localparam int BIST_N = 300;
  localparam int LOAD_N = 9000;
  localparam int HALF_N = 2;
  localparam int ROM_BITS = 2048;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic ext_reset_n = 1'b0;
  logic fitted = 1'b0;
  logic slow = 1'b0;
  logic rom_present_n, srom_data, srom_clk, srom_oe_n, core_reset, bist_fail, bist_busy, load_busy;
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 32'h68b5;
  logic [31:0] r;

  always #2.5 clk_sys = ~clk_sys;

  reset_selftest_srom_load_sequencer #(.BIST_END_SYS(BIST_N), .LOAD_END_SYS(LOAD_N), .SROM_HALF(HALF_N)) dut (
    .clk_sys(clk_sys), .reset(reset), .ext_reset_n(ext_reset_n), .rom_present_n(rom_present_n),
    .srom_data(srom_data), .srom_clk(srom_clk), .srom_oe_n(srom_oe_n), .core_reset(core_reset),
    .bist_fail(bist_fail), .bist_busy(bist_busy), .load_busy(load_busy));

  srom_model rom (.clk_sys(clk_sys), .fitted(fitted), .slow(slow), .srom_clk(srom_clk),
    .srom_oe_n(srom_oe_n), .srom_data(srom_data), .rom_present_n(rom_present_n));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // A wait that runs past its bound ends the run
  task automatic bound(input int n, input int lim);
    if (n > lim) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : bound

  // Word the ROM sends at index w, first bit into the top of the word
  function automatic logic [31:0] rom_word(input logic [6:0] w);
    return {w ^ 7'h55, 1'b1, ~w, 1'b0, w, 2'h2, ~w ^ 7'h2a};
  endfunction : rom_word

  // Sample just after the edge so that its updates have landed
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  // Pull board reset or system reset mid-run; the sequencer must fall back to hold
  task automatic abort_now(input logic by_reset);
    if (by_reset) reset <= 1'b1;
    else ext_reset_n <= 1'b0;
    repeat (4) tick();
    check({27'h0, core_reset, bist_busy, load_busy, srom_oe_n, srom_clk}, 32'h12);
    check({31'h0, bist_fail}, 32'h0);
    reset <= 1'b0;
  endtask : abort_now

  // ----------------------------------------------------------------
  // One boot from board reset release to core reset release
  // ----------------------------------------------------------------
  task automatic boot(input logic has_rom, input logic lag, input logic async_rel, input int abort_at,
                      input logic by_reset);
    int n;
    int rises;
    int hi;
    int held;
    held = 0;
    @(posedge clk_sys);
    ext_reset_n <= 1'b0;
    fitted <= has_rom;
    slow <= lag;
    repeat (4) @(posedge clk_sys);
    if (async_rel) begin
      #2;
      ext_reset_n = 1'b1;
    end else begin
      ext_reset_n <= 1'b1;
    end
    n = 0;
    do begin
      tick();
      n++;
    end while (bist_busy !== 1'b1 && n <= 20);
    bound(n, 20);
    check(n, 3);
    // Count the self-test length while core reset must stay asserted
    n = 0;
    while (bist_busy === 1'b1 && n <= BIST_N) begin
      if (n == abort_at) begin
        abort_now(by_reset);
        return;
      end
      held += (core_reset !== 1'b1) + (srom_clk !== 1'b0);
      n++;
      tick();
    end
    bound(n, BIST_N);
    check(n, BIST_N);
    if (!has_rom) begin
      if (core_reset === 1'b1) tick();
      check({30'h0, core_reset, load_busy}, 32'h0);
    end else begin
      check({31'h0, load_busy}, 32'h1);
      n = 0;
      rises = 0;
      hi = 0;
      while (load_busy === 1'b1 && n <= LOAD_N) begin
        if (n + BIST_N == abort_at) begin
          abort_now(by_reset);
          return;
        end
        if (n == 5) fitted <= ~has_rom; // Strap is read once; a late change must not matter
        held += (core_reset !== 1'b1) + (n > 0 && srom_oe_n !== 1'b0);
        if (srom_clk === 1'b1) begin
          hi++;
        end else if (hi > 0) begin
          check(hi, HALF_N);
          rises++;
          hi = 0;
        end
        n++;
        tick();
      end
      bound(n, LOAD_N);
      check(n, LOAD_N);
      check(rises, ROM_BITS);
      check({30'h0, srom_oe_n, srom_clk}, 32'h2);
      if (core_reset === 1'b1) tick();
      check({31'h0, core_reset}, 32'h0);
      // Every word must have landed whole, at its own address, first bit on top
      for (int w = 0; w < ROM_BITS / 32; w++) begin
        check(dut.u_store.mem[w], rom_word(7'(w)));
      end
    end
    check(held, 0);
    check({31'h0, bist_fail}, 32'h0);
  endtask : boot

  // ----------------------------------------------------------------
  // Main sequence: corner cases first, then random boots
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    boot(1'b0, 1'b0, 1'b0, -1, 1'b0);
    boot(1'b1, 1'b0, 1'b1, -1, 1'b0);
    boot(1'b1, 1'b1, 1'b0, -1, 1'b0);
    boot(1'b0, 1'b0, 1'b0, 0, 1'b0);
    boot(1'b1, 1'b0, 1'b0, BIST_N - 1, 1'b0);
    boot(1'b1, 1'b1, 1'b1, BIST_N + 1000, 1'b1);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      boot(r[0], r[1], r[2], r[3] ? int'(r[20:8]) % (BIST_N + LOAD_N) : -1, r[4]);
    end
    print_verdict();
  end
endmodule : tb_reset_selftest_srom_load_sequencer
